/* File: rtl/syt_axil_slave.sv */
`timescale 1ns/1ns
`default_nettype none
// Single-beat AXI4-Lite slave turning accesses into one-cycle strobes
module syt_axil_slave
    import syt_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [5:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [5:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output syt_reg_s         regReq,
    input  wire logic [7:0]  regRdata,
    input  wire logic        regHit
);
    logic       awHave_q;
    logic       wHave_q;
    logic [5:0] awAddr_q;
    logic [7:0] wData_q;
    logic       wLane_q;
    logic       doWrite;
    logic       doRead;

    assign awready = !awHave_q && !bvalid;
    assign wready  = !wHave_q && !bvalid;
    // Held off while a write completes, so a taken address is never lost
    assign arready = !rvalid && !doWrite;
    assign doWrite = awHave_q && wHave_q && !bvalid;
    // Reads lose the cycle to writes so only one strobe fires at a time
    assign doRead  = arvalid && arready && !doWrite;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            awAddr_q <= 6'h00;
            wData_q  <= 8'h00;
            wLane_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHave_q <= 1'b1;
                wData_q <= wdata[7:0];
                wLane_q <= wstrb[0];
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q  <= 1'b0;
            end
        end
    end

    always_comb begin
        regReq.wr   = doWrite && wLane_q;
        regReq.rd   = doRead;
        regReq.addr = doWrite ? awAddr_q : araddr;
        regReq.data = wData_q;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OK;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= regHit ? RESP_OK : RESP_ERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OK;
        end else if (doRead) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, regRdata};
            rresp  <= regHit ? RESP_OK : RESP_ERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : syt_axil_slave
`default_nettype wire

/* File: rtl/syt_divider.sv */
`timescale 1ns/1ns
`default_nettype none
// Power-of-two tick divider
module syt_divider
    import syt_pkg::*;
#(
    parameter int EXP_W = 3,
    parameter int CNT_W = 7
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [EXP_W-1:0] exponent,
    output logic                  tick
);
    logic [CNT_W-1:0] div_q;
    logic [CNT_W-1:0] terminal;

    // Terminal 2^exp - 1; a stale count above it still ends the period
    assign terminal = CNT_W'((1 << exponent) - 1);
    assign tick     = run && (div_q >= terminal);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (clear) begin
            div_q <= '0;
        end else if (run) begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end
endmodule : syt_divider
`default_nettype wire

/* File: rtl/syt_pkg.sv */
package syt_pkg;
    // Register index; the bus byte address is four times it
    localparam int IDX_CTRL  = 0;
    localparam int IDX_IEN   = 1;
    localparam int IDX_STAT  = 2;
    localparam int IDX_EVGEN = 3;
    localparam int IDX_CNTH  = 4;
    localparam int IDX_CNTL  = 5;
    localparam int IDX_DIV   = 6;
    localparam int IDX_WRAPH = 7;
    localparam int IDX_WRAPL = 8;
    localparam int IDX_TRIG  = 9;
    localparam logic [5:0] OFF_CTRL  = 6'(4 * IDX_CTRL);
    localparam logic [5:0] OFF_IEN   = 6'(4 * IDX_IEN);
    localparam logic [5:0] OFF_STAT  = 6'(4 * IDX_STAT);
    localparam logic [5:0] OFF_EVGEN = 6'(4 * IDX_EVGEN);
    localparam logic [5:0] OFF_CNTH  = 6'(4 * IDX_CNTH);
    localparam logic [5:0] OFF_CNTL  = 6'(4 * IDX_CNTL);
    localparam logic [5:0] OFF_DIV   = 6'(4 * IDX_DIV);
    localparam logic [5:0] OFF_WRAPH = 6'(4 * IDX_WRAPH);
    localparam logic [5:0] OFF_WRAPL = 6'(4 * IDX_WRAPL);
    localparam logic [5:0] OFF_TRIG  = 6'(4 * IDX_TRIG);
    localparam int BIT_CEN  = 0;
    localparam int BIT_UINH = 1;
    localparam int BIT_USRC = 2;
    localparam int BIT_SSHT = 3;
    localparam int BIT_RBUF = 7;
    localparam logic [15:0] WRAP_RST = 16'hFFFF;
    localparam logic [2:0]  DIV_RST  = 3'h0;
    localparam logic [1:0]  RESP_OK  = 2'b00;
    localparam logic [1:0]  RESP_ERR = 2'b10;

    typedef struct packed {
        logic       countEnable;
        logic       updateInhibit;
        logic       updateSourceSelect;
        logic       singleShot;
        logic       reloadBufferingEnable;
    } syt_ctrl_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] data;
    } syt_reg_s;
endpackage : syt_pkg

/* File: rtl/syt_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// Auto-reload system timer, byte registers over AXI4-Lite
module syt_timer
    import syt_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [5:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [5:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             updateIrq,
    output logic             convTrigger,
    output logic             overflowPulse
);
    syt_reg_s    regReq;
    logic [7:0]  regRdata;
    logic        regHit;
    syt_ctrl_s   ctrl_q;
    logic        irqEn_q;
    logic        updateFlag_q;
    logic        forceUpdate_q;
    logic        trigSel_q;
    logic [15:0] count_q;
    logic [7:0]  lowLatch_q;
    logic [2:0]  divPre_q;
    logic [2:0]  divAct_q;
    logic [15:0] wrapPre_q;
    logic [15:0] wrapAct_q;
    logic        wrapLock_q;
    logic        tick;
    logic        run;
    logic        wrapHit;
    logic        updEvent;
    logic        flagSet;
    logic        wrCtrl;
    logic        wrStat;
    logic        wrEvgen;
    logic        wrCntH;
    logic        wrCntL;
    logic        wrDiv;
    logic        wrWrapH;
    logic        wrWrapL;
    logic        rdCntH;

    syt_axil_slave u_bus (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .awready  (awready),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .wready   (wready),
        .bresp    (bresp),
        .bvalid   (bvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .arready  (arready),
        .rdata    (rdata),
        .rresp    (rresp),
        .rvalid   (rvalid),
        .rready   (rready),
        .regReq   (regReq),
        .regRdata (regRdata),
        .regHit   (regHit)
    );

    function automatic logic hitW(input syt_reg_s r, input logic [5:0] off);
        hitW = r.wr && (r.addr == off);
    endfunction : hitW

    assign wrCtrl  = hitW(regReq, OFF_CTRL);
    assign wrStat  = hitW(regReq, OFF_STAT);
    assign wrEvgen = hitW(regReq, OFF_EVGEN);
    assign wrCntH  = hitW(regReq, OFF_CNTH);
    assign wrCntL  = hitW(regReq, OFF_CNTL);
    assign wrDiv   = hitW(regReq, OFF_DIV);
    assign wrWrapH = hitW(regReq, OFF_WRAPH);
    assign wrWrapL = hitW(regReq, OFF_WRAPL);
    assign rdCntH  = regReq.rd && (regReq.addr == OFF_CNTH);

    // Zero limit halts everything, divider included
    assign run = ctrl_q.countEnable && (wrapAct_q != 16'h0000);

    syt_divider #(
        .EXP_W (3),
        .CNT_W (7)
    ) u_div (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .run      (run),
        .clear    (forceUpdate_q),
        .exponent (divAct_q),
        .tick     (tick)
    );

    assign wrapHit = tick && (count_q >= wrapAct_q);
    // Forced update only counts when not inhibited
    assign updEvent = (wrapHit || forceUpdate_q)
                    && !ctrl_q.updateInhibit;
    assign flagSet  = updEvent
                    && (wrapHit || !ctrl_q.updateSourceSelect);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_q.countEnable        <= regReq.data[BIT_CEN];
                ctrl_q.updateInhibit      <= regReq.data[BIT_UINH];
                ctrl_q.updateSourceSelect <= regReq.data[BIT_USRC];
                ctrl_q.singleShot         <= regReq.data[BIT_SSHT];
                ctrl_q.reloadBufferingEnable <= regReq.data[BIT_RBUF];
            end
            // Hardware stop wins over a same-cycle software write
            if (updEvent && ctrl_q.singleShot) begin
                ctrl_q.countEnable <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEn_q <= 1'b0;
        end else if (hitW(regReq, OFF_IEN)) begin
            irqEn_q <= regReq.data[0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trigSel_q <= 1'b0;
        end else if (hitW(regReq, OFF_TRIG)) begin
            trigSel_q <= regReq.data[0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            forceUpdate_q <= 1'b0;
        end else if (wrEvgen && regReq.data[0]) begin
            forceUpdate_q <= 1'b1;
        end else begin
            forceUpdate_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            updateFlag_q <= 1'b0;
        end else if (flagSet) begin
            updateFlag_q <= 1'b1; // set wins over clear
        end else if (wrStat && !regReq.data[0]) begin
            updateFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= 16'h0000;
        end else if (forceUpdate_q) begin
            count_q <= 16'h0000;
        end else if (wrCntH) begin
            count_q[15:8] <= regReq.data;
        end else if (wrCntL) begin
            count_q[7:0] <= regReq.data;
        end else if (wrapHit) begin
            count_q <= 16'h0000;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Low byte frozen so a two-byte read is coherent
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowLatch_q <= 8'h00;
        end else if (rdCntH) begin
            lowLatch_q <= count_q[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divPre_q <= DIV_RST;
        end else if (wrDiv) begin
            divPre_q <= regReq.data[2:0];
        end
    end

    // Active ratio moves only on an event, never in mid-period
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divAct_q <= DIV_RST;
        end else if (updEvent) begin
            divAct_q <= divPre_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrapPre_q  <= WRAP_RST;
            wrapLock_q <= 1'b0;
        end else begin
            if (wrWrapH) begin
                wrapPre_q[15:8] <= regReq.data;
                wrapLock_q      <= 1'b1;
            end
            if (wrWrapL) begin
                wrapPre_q[7:0] <= regReq.data;
                wrapLock_q     <= 1'b0;
            end
        end
    end

    // Shadow takes preload on the event unless wrapLock_q is set; counter restarts from zero
    // in the same edge, so the next period already uses it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrapAct_q <= WRAP_RST;
        end else if (!ctrl_q.reloadBufferingEnable && wrWrapL) begin
            wrapAct_q <= {wrapPre_q[15:8], regReq.data};
        end else if (!ctrl_q.reloadBufferingEnable && wrWrapH) begin
            wrapAct_q <= {regReq.data, wrapPre_q[7:0]};
        end else if (updEvent && !wrapLock_q) begin
            wrapAct_q <= wrapPre_q;
        end
    end

    always_comb begin
        regHit   = 1'b1;
        regRdata = 8'h00;
        case (regReq.addr)
            OFF_CTRL:  regRdata = {ctrl_q.reloadBufferingEnable, 3'b000,
                                   ctrl_q.singleShot,
                                   ctrl_q.updateSourceSelect,
                                   ctrl_q.updateInhibit,
                                   ctrl_q.countEnable};
            OFF_IEN:   regRdata = {7'h00, irqEn_q};
            OFF_STAT:  regRdata = {7'h00, updateFlag_q};
            OFF_EVGEN: regRdata = 8'h00;
            OFF_CNTH:  regRdata = count_q[15:8];
            OFF_CNTL:  regRdata = lowLatch_q;
            OFF_DIV:   regRdata = {5'h00, divPre_q};
            OFF_WRAPH: regRdata = wrapPre_q[15:8];
            OFF_WRAPL: regRdata = wrapPre_q[7:0];
            OFF_TRIG:  regRdata = {7'h00, trigSel_q};
            default:   regHit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            convTrigger <= 1'b0;
        end else begin
            convTrigger <= flagSet && trigSel_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            overflowPulse <= 1'b0;
        end else begin
            overflowPulse <= wrapHit && !ctrl_q.updateInhibit;
        end
    end

    // Flag set folded in so the request rises together with the flag
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            updateIrq <= 1'b0;
        end else begin
            updateIrq <= (updateFlag_q || flagSet) && irqEn_q;
        end
    end
endmodule : syt_timer
`default_nettype wire

/* File: sim/syt_timer_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module syt_timer_sva
    import syt_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        convTrigger,
    input wire logic        overflowPulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    sequence rdRefused;
        rvalid && rresp == RESP_ERR;
    endsequence
    wr_answer_a: assert property (wrTaken |-> ##[1:2] bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (rdTaken |=> rvalid)
        else $error("read answer late");
    rd_busy_a: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    wr_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    err_zero_a: assert property (rdRefused |-> rdata == 32'h0)
        else $error("refused read returned data");
    ovf_pulse_a: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse too long");
    trig_pulse_a: assert property (convTrigger |=> !convTrigger)
        else $error("trigger pulse too long");
    rd_done_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer not released");
    wr_done_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not released");
endmodule : syt_timer_sva
bind syt_timer syt_timer_sva syt_timer_sva_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .convTrigger(convTrigger),
    .overflowPulse(overflowPulse)
);
`default_nettype wire

/* File: sim/test_syt_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_syt_timer
    import syt_pkg::*;
;
    localparam int CYC_LIMIT = 30000;
    logic        refClk, rstB, awvalid, wvalid, arvalid;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        updateIrq, convTrigger, overflowPulse;
    int          errTotal = 0, nChecks = 0, cyc = 0, ovfCnt = 0;
    int          trigCnt = 0, lastOvf = 0, ovfGap = 0, o;

    syt_timer syt_timer_inst (
        .ref_clk(refClk), .rst_b(rstB), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'h1), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(1'h1),
        .updateIrq(updateIrq), .convTrigger(convTrigger),
        .overflowPulse(overflowPulse)
    );

    always #10 refClk = ~refClk;

    // Wrap spacing measured in clocks between overflow pulses
    always @(posedge refClk) begin
        cyc <= cyc + 1;
        if (overflowPulse === 1'h1) begin
            ovfCnt  <= ovfCnt + 1;
            ovfGap  <= cyc - lastOvf;
            lastOvf <= cyc;
        end
        if (convTrigger === 1'h1)
            trigCnt <= trigCnt + 1;
        if (cyc == CYC_LIMIT) begin
            errTotal = errTotal + 1;
            print_verdict();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks = nChecks + 1;
        if (seen !== exp) begin
            errTotal = errTotal + 1;
            $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Hangs are left to the cycle ceiling above
    task wr(input logic [5:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        do begin
            @(posedge refClk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rr = bresp;
    endtask : wr

    task rd(input logic [5:0] a);
        araddr  <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge refClk);
            if (arvalid && arready)
                arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rv = rdata;
        rr = rresp;
    endtask : rd

    task rc(input logic [5:0] a, input logic [31:0] e);
        rd(a);
        chk({24'h0, rv[7:0]}, e);
    endtask : rc

    task idle(input int n);
        repeat (n) @(posedge refClk);
    endtask : idle

    task waitOvf(input int n);
        int t;
        t = ovfCnt + n;
        while (ovfCnt < t) @(posedge refClk);
    endtask : waitOvf

    task tDefaults();
        rc(OFF_CTRL, 32'h0);
        rc(OFF_DIV, 32'h0);
        rc(OFF_WRAPH, 32'hFF);
        rc(OFF_WRAPL, 32'hFF);
        rc(OFF_STAT, 32'h0);
        rc(OFF_IEN, 32'h0);
        rc(OFF_TRIG, 32'h0);
        rc(OFF_CNTH, 32'h0);
        wstrb <= 4'h0;
        wr(OFF_IEN, 8'h01);
        chk({30'h0, rr}, {30'h0, RESP_OK});
        wstrb <= 4'hF;
        rc(OFF_IEN, 32'h0);
        rd(6'h3C);
        chk(rv, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_ERR});
        wr(6'h3C, 8'h55);
        chk({30'h0, rr}, {30'h0, RESP_ERR});
    endtask : tDefaults

    task tInit();
        wr(OFF_CTRL, 8'h00);
        wr(OFF_CTRL, 8'h02);
        wr(OFF_WRAPH, 8'h00);
        wr(OFF_WRAPL, 8'h09);
        wr(OFF_DIV, 8'h00);
        wr(OFF_EVGEN, 8'h01);
        rc(OFF_STAT, 32'h0);
        rc(OFF_EVGEN, 32'h0);
        wr(OFF_TRIG, 8'h01);
        wr(OFF_CTRL, 8'h01);
        waitOvf(3);
        chk(ovfGap, 32'hA);
        rc(OFF_STAT, 32'h1);
    endtask : tInit

    // Third pulse after a change, so the old divider phase has died out
    task tDivider();
        for (int e = 0; e < 8; e++) begin
            wr(OFF_DIV, e[7:0]);
            rc(OFF_DIV, e);
            waitOvf(3);
            chk(ovfGap, 10 << e);
        end
        wr(OFF_DIV, 8'h00);
        waitOvf(1);
        wr(OFF_CTRL, 8'h00);
        idle(3);
        chk(trigCnt, ovfCnt);
        chk(updateIrq, 1'h0);
    endtask : tDivider

    task tForce();
        int t0;
        wr(OFF_STAT, 8'h00);
        rc(OFF_STAT, 32'h0);
        wr(OFF_CNTH, 8'h12);
        wr(OFF_CTRL, 8'h04);
        t0 = trigCnt;
        wr(OFF_EVGEN, 8'h01);
        rc(OFF_STAT, 32'h0);
        rc(OFF_CNTH, 32'h0);
        rc(OFF_EVGEN, 32'h0);
        wr(OFF_CTRL, 8'h00);
        wr(OFF_EVGEN, 8'h01);
        rc(OFF_STAT, 32'h1);
        wr(OFF_STAT, 8'h01);
        rc(OFF_STAT, 32'h1);
        idle(2);
        chk(trigCnt, t0 + 1);
    endtask : tForce

    task tLatch();
        wr(OFF_CNTH, 8'h12);
        wr(OFF_CNTL, 8'h34);
        rc(OFF_CNTH, 32'h12);
        wr(OFF_CNTL, 8'h99);
        rc(OFF_CNTL, 32'h34);
        rc(OFF_CNTH, 32'h12);
        rc(OFF_CNTL, 32'h99);
    endtask : tLatch

    task tIrq();
        chk(updateIrq, 1'h0);
        wr(OFF_IEN, 8'h01);
        idle(2);
        chk(updateIrq, 1'h1);
        wr(OFF_STAT, 8'h00);
        idle(2);
        chk(updateIrq, 1'h0);
        wr(OFF_IEN, 8'h00);
    endtask : tIrq

    task tInhibit();
        wr(OFF_CTRL, 8'h03);
        o = ovfCnt;
        idle(40);
        chk(ovfCnt, o);
        rc(OFF_STAT, 32'h0);
        wr(OFF_CTRL, 8'h00);
    endtask : tInhibit

    task tZero();
        wr(OFF_WRAPH, 8'h00);
        wr(OFF_WRAPL, 8'h00);
        wr(OFF_CNTH, 8'h00);
        wr(OFF_CNTL, 8'h00);
        wr(OFF_CTRL, 8'h01);
        o = ovfCnt;
        idle(30);
        rc(OFF_CNTH, 32'h0);
        rc(OFF_CNTL, 32'h0);
        chk(ovfCnt, o);
    endtask : tZero

    task tBuffered();
        wr(OFF_CTRL, 8'h81);
        wr(OFF_WRAPH, 8'h00);
        wr(OFF_WRAPL, 8'h04);
        idle(20);
        chk(ovfCnt, o);
        rc(OFF_WRAPL, 32'h4);
        wr(OFF_EVGEN, 8'h01);
        waitOvf(3);
        chk(ovfGap, 32'h5);
        wr(OFF_WRAPH, 8'h01);
        waitOvf(3);
        chk(ovfGap, 32'h5);
        wr(OFF_WRAPL, 8'h04);
        waitOvf(3);
        chk(ovfGap, 32'h105);
        wr(OFF_CTRL, 8'h00);
    endtask : tBuffered

    task tSingle();
        wr(OFF_WRAPH, 8'h00);
        wr(OFF_WRAPL, 8'h09);
        wr(OFF_EVGEN, 8'h01);
        wr(OFF_CTRL, 8'h09);
        waitOvf(1);
        o = ovfCnt;
        idle(30);
        chk(ovfCnt, o);
        rc(OFF_CTRL, 32'h8);
    endtask : tSingle

    task print_verdict();
        $display("Checks %0d, errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        refClk  = 1'h0;
        rstB    = 1'h0;
        awvalid = 1'h0;
        wvalid  = 1'h0;
        arvalid = 1'h0;
        awaddr  = 6'h00;
        araddr  = 6'h00;
        wdata   = 32'h0;
        wstrb   = 4'hF;
        repeat (8) @(posedge refClk);
        rstB <= 1'h1;
        @(posedge refClk);
        tDefaults();
        tInit();
        tDivider();
        tForce();
        tLatch();
        tIrq();
        tInhibit();
        tZero();
        tBuffered();
        tSingle();
        print_verdict();
    end
endmodule : test_syt_timer
`default_nettype wire
